/* hw/sarc_pkg.sv */
package sarc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int        ADDR_W          = 10;
  localparam int        DATA_W          = 8;
  localparam logic [9:0] TEMP_LOW_ADDR  = 10'h208;
  localparam logic [9:0] TEMP_HIGH_ADDR = 10'h209;
  localparam logic [9:0] HUMID_LOW_ADDR = 10'h20a;
  localparam logic [9:0] HUMID_HIGH_ADDR = 10'h20b;
  localparam logic [9:0] TEMP_CTRL_ADDR = 10'h210;
  localparam logic [9:0] HUMID_CTRL_ADDR = 10'h211;
  localparam logic [9:0] CLOCK_CTRL_ADDR = 10'h212;
  localparam logic [9:0] ALARM_FLAGS_ADDR = 10'h214;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int LOW_EN_BIT     = 0;
  localparam int HIGH_EN_BIT    = 1;
  localparam int OSC_RUN_BIT    = 0;
  localparam int SEC_UNIT_BIT   = 1;
  localparam int TEMP_LOW_FLAG  = 0;
  localparam int TEMP_HIGH_FLAG = 1;
  localparam int HUMID_LOW_FLAG = 2;
  localparam int HUMID_HIGH_FLAG = 3;
  localparam int BROWNOUT_FLAG  = 7;
  localparam int FLAG_W         = 4;
  localparam int EN_W           = 2;

  localparam logic [7:0] ZERO_FILL   = 8'h00;
  localparam logic [7:0] HUMID_FILL  = 8'hfc;
  localparam logic [7:0] FLAGS_FILL  = 8'h70;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;
  localparam logic [7:0] BYTE_RESET  = 8'h00;
  localparam logic [1:0] EN_RESET    = 2'h0;
  localparam logic [3:0] FLAG_RESET  = 4'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int         SECS_PER_MIN = 60;
  localparam logic [5:0] MIN_LAST     = 6'(SECS_PER_MIN - 1);
  localparam logic [5:0] MIN_RESET    = 6'h00;

  typedef enum logic {SARC_RD_IDLE, SARC_RD_ANSWER} sarc_rd_state_t;

endpackage

/* hw/sarc_cmp_if.sv */
`timescale 1ns/10ps
interface sarc_cmp_if;
  logic [7:0] temp_low;
  logic [7:0] temp_high;
  logic [7:0] humid_low;
  logic [7:0] humid_high;
  logic [1:0] temp_en;
  logic [1:0] humid_en;
  logic       mission;
  logic       temp_valid;
  logic       humid_valid;
  logic [7:0] temp_msb;
  logic [7:0] humid_msb;
  logic [3:0] hits;

  modport ctrl (output temp_low, temp_high, humid_low, humid_high, temp_en, humid_en,
                output mission, temp_valid, humid_valid, temp_msb, humid_msb,
                input  hits);
  modport eval (input  temp_low, temp_high, humid_low, humid_high, temp_en, humid_en,
                input  mission, temp_valid, humid_valid, temp_msb, humid_msb,
                output hits);
endinterface

/* hw/sarc_alarm_eval.sv */
`timescale 1ns/10ps
module sarc_alarm_eval (
  // Thresholds, enables, samples in; hits out
  sarc_cmp_if.eval cmp
);

  // ----------------------------------------------------------------
  // Comparisons
  // ----------------------------------------------------------------
  // Unsigned, inclusive: a sample equal to the threshold alarms
  function automatic logic at_or_below(input logic [7:0] v, input logic [7:0] lim);
    at_or_below = (v <= lim);
  endfunction

  function automatic logic at_or_above(input logic [7:0] v, input logic [7:0] lim);
    at_or_above = (v >= lim);
  endfunction

  logic temp_go;
  logic humid_go;

  assign temp_go  = cmp.mission & cmp.temp_valid;
  assign humid_go = cmp.mission & cmp.humid_valid;

  always_comb begin
    cmp.hits = sarc_pkg::FLAG_RESET;
    cmp.hits[sarc_pkg::TEMP_LOW_FLAG] = temp_go                      // see RULE1
      & cmp.temp_en[sarc_pkg::LOW_EN_BIT]                            // see RULE2
      & at_or_below(cmp.temp_msb, cmp.temp_low);                     // see RULE17
    cmp.hits[sarc_pkg::TEMP_HIGH_FLAG] = temp_go
      & cmp.temp_en[sarc_pkg::HIGH_EN_BIT]                           // see RULE3
      & at_or_above(cmp.temp_msb, cmp.temp_high);
    cmp.hits[sarc_pkg::HUMID_LOW_FLAG] = humid_go                    // see RULE6
      & cmp.humid_en[sarc_pkg::LOW_EN_BIT]                           // see RULE7
      & at_or_below(cmp.humid_msb, cmp.humid_low);                   // see RULE18
    cmp.hits[sarc_pkg::HUMID_HIGH_FLAG] = humid_go
      & cmp.humid_en[sarc_pkg::HIGH_EN_BIT]                          // see RULE8
      & at_or_above(cmp.humid_msb, cmp.humid_high);
  end

endmodule

/* hw/sarc_ctrl.sv */
// Function
// RULE1: Temperature alarm needs both an alarming reading and its enable bit.
// RULE2: In mission, reading at or below low threshold sets low flag if enabled.
// RULE3: In mission, reading at or above high threshold sets high flag if enabled.
// RULE4: Temperature control register: bit 0 low enable, bit 1 high enable.
// RULE5: Temperature low and high flags live in the alarm flags register.
// RULE6: Humidity alarm needs both an alarming reading and its enable bit.
// RULE7: In mission, humidity at or below low threshold sets flag if enabled.
// RULE8: In mission, humidity at or above high threshold sets flag if enabled.
// RULE9: Humidity low and high flags live in the alarm flags register.
// RULE10: During a mission the control registers are read only.
// RULE11: Upper six bits of temperature and clock control read zero.
// RULE12: Upper six bits of humidity control always read one.
// RULE13: Clock control bit 0 runs the oscillator; zero stops it.
// RULE14: Host must not request a conversion while the oscillator is stopped.
// RULE15: Clock control bit 1 selects seconds when one, minutes when zero.
// RULE16: Host should stop the oscillator whenever the device is idle.
// RULE17: Temperature comparison uses only the result's upper byte.
// RULE18: Humidity comparison uses only the raw reading's upper byte.
// RULE19: Alarm flags stay set for the rest of the mission.
`timescale 1ns/10ps
module sarc_ctrl (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  // Register port from the serial command layer
  input  wire logic [9:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  output logic             reg_rvalid,
  // Mission sequencer
  input  wire logic        mission_active,
  input  wire logic        mission_start,
  input  wire logic        brownout_event,
  // Conversion results
  input  wire logic [15:0] temp_result,
  input  wire logic        temp_valid,
  input  wire logic [15:0] humid_result,
  input  wire logic        humid_valid,
  // Conversion requests
  input  wire logic        conv_req,
  output logic             conv_start,
  output logic             conv_refused,
  // Real-time clock
  input  wire logic        second_tick,
  output logic             oscillator_run,
  output logic             seconds_unit_select,
  output logic             sample_unit_tick,
  // Alarm summary
  output logic             alarm_any
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_sync_reg;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  logic rst_n;
  assign rst_n = rst_sync_reg;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0] temp_low_threshold_reg;
  logic [7:0] temp_high_threshold_reg;
  logic [7:0] humid_low_threshold_reg;
  logic [7:0] humid_high_threshold_reg;
  logic [1:0] temp_alarm_enables_reg;
  logic [1:0] humid_alarm_enables_reg;
  logic [1:0] clock_control_reg;
  logic [3:0] alarm_flags_reg;
  logic       brownout_flag_reg;

  logic temp_low_alarm_enable;
  logic temp_high_alarm_enable;
  logic humid_low_alarm_enable;
  logic humid_high_alarm_enable;

  assign temp_low_alarm_enable   = temp_alarm_enables_reg[sarc_pkg::LOW_EN_BIT];
  assign temp_high_alarm_enable  = temp_alarm_enables_reg[sarc_pkg::HIGH_EN_BIT];
  assign humid_low_alarm_enable  = humid_alarm_enables_reg[sarc_pkg::LOW_EN_BIT];
  assign humid_high_alarm_enable = humid_alarm_enables_reg[sarc_pkg::HIGH_EN_BIT];

  // Writes land only outside a mission
  logic wr_ok;
  assign wr_ok = clk_en & reg_wr & ~mission_active;           // see RULE10

  function automatic logic hit(input logic [9:0] a, input logic [9:0] target);
    hit = (a == target);
  endfunction

  // ----------------------------------------------------------------
  // Write strobes
  // ----------------------------------------------------------------
  // One strobe per writable register; the flag register and unmapped
  // addresses decode to nothing, so writes there vanish silently.
  logic wr_temp_low;
  logic wr_temp_high;
  logic wr_humid_low;
  logic wr_humid_high;
  logic wr_temp_ctrl;
  logic wr_humid_ctrl;
  logic wr_clock_ctrl;

  assign wr_temp_low   = wr_ok & hit(reg_addr, sarc_pkg::TEMP_LOW_ADDR);
  assign wr_temp_high  = wr_ok & hit(reg_addr, sarc_pkg::TEMP_HIGH_ADDR);
  assign wr_humid_low  = wr_ok & hit(reg_addr, sarc_pkg::HUMID_LOW_ADDR);
  assign wr_humid_high = wr_ok & hit(reg_addr, sarc_pkg::HUMID_HIGH_ADDR);
  assign wr_temp_ctrl  = wr_ok & hit(reg_addr, sarc_pkg::TEMP_CTRL_ADDR);
  assign wr_humid_ctrl = wr_ok & hit(reg_addr, sarc_pkg::HUMID_CTRL_ADDR);
  assign wr_clock_ctrl = wr_ok & hit(reg_addr, sarc_pkg::CLOCK_CTRL_ADDR);

  // ----------------------------------------------------------------
  // Thresholds
  // ----------------------------------------------------------------
  // Thresholds lock with the control registers so a mission sees
  // one consistent set of limits from start to stop.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      temp_low_threshold_reg   <= sarc_pkg::BYTE_RESET;
      temp_high_threshold_reg  <= sarc_pkg::BYTE_RESET;
      humid_low_threshold_reg  <= sarc_pkg::BYTE_RESET;
      humid_high_threshold_reg <= sarc_pkg::BYTE_RESET;
    end else begin
      if (wr_temp_low) begin
        temp_low_threshold_reg <= reg_wdata;
      end
      if (wr_temp_high) begin
        temp_high_threshold_reg <= reg_wdata;
      end
      if (wr_humid_low) begin
        humid_low_threshold_reg <= reg_wdata;
      end
      if (wr_humid_high) begin
        humid_high_threshold_reg <= reg_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Only the two live bits are stored; the rest cannot be changed
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      temp_alarm_enables_reg <= sarc_pkg::EN_RESET;
    end else if (wr_temp_ctrl) begin
      temp_alarm_enables_reg <= reg_wdata[sarc_pkg::EN_W-1:0];   // see RULE4
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      humid_alarm_enables_reg <= sarc_pkg::EN_RESET;
    end else if (wr_humid_ctrl) begin
      humid_alarm_enables_reg <= reg_wdata[sarc_pkg::EN_W-1:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      clock_control_reg <= sarc_pkg::EN_RESET;
    end else if (wr_clock_ctrl) begin
      clock_control_reg <= reg_wdata[sarc_pkg::EN_W-1:0];        // see RULE13
    end
  end

  assign oscillator_run      = clock_control_reg[sarc_pkg::OSC_RUN_BIT];   // see RULE13
  assign seconds_unit_select = clock_control_reg[sarc_pkg::SEC_UNIT_BIT];  // see RULE15

  // ----------------------------------------------------------------
  // Alarm evaluation
  // ----------------------------------------------------------------
  sarc_cmp_if cmp ();

  assign cmp.temp_low    = temp_low_threshold_reg;
  assign cmp.temp_high   = temp_high_threshold_reg;
  assign cmp.humid_low   = humid_low_threshold_reg;
  assign cmp.humid_high  = humid_high_threshold_reg;
  assign cmp.temp_en     = {temp_high_alarm_enable, temp_low_alarm_enable};
  assign cmp.humid_en    = {humid_high_alarm_enable, humid_low_alarm_enable};
  assign cmp.mission     = mission_active;
  assign cmp.temp_valid  = temp_valid;
  assign cmp.humid_valid = humid_valid;
  assign cmp.temp_msb    = temp_result[15:8];                 // see RULE17
  assign cmp.humid_msb   = humid_result[15:8];                // see RULE18

  sarc_alarm_eval u_eval (
    .cmp (cmp.eval)
  );

  // ----------------------------------------------------------------
  // Sticky flags
  // ----------------------------------------------------------------
  // Cleared only when a new mission starts; a hit in that same cycle
  // still sets its flag so a first-sample alarm is never lost.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_flags_reg <= sarc_pkg::FLAG_RESET;
    end else if (clk_en) begin
      if (mission_start) begin
        alarm_flags_reg <= cmp.hits;
      end else begin
        alarm_flags_reg <= alarm_flags_reg | cmp.hits;        // see RULE19
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      brownout_flag_reg <= 1'b0;
    end else if (clk_en) begin
      if (brownout_event) begin
        brownout_flag_reg <= 1'b1;
      end else if (mission_start) begin
        brownout_flag_reg <= 1'b0;
      end
    end
  end

  assign alarm_any = |alarm_flags_reg;

  // ----------------------------------------------------------------
  // Conversion guard
  // ----------------------------------------------------------------
  // A conversion with the oscillator stopped would wedge the sensor
  // front end; refuse it here rather than trust every host.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      conv_start   <= 1'b0;
      conv_refused <= 1'b0;
    end else if (clk_en) begin
      conv_start   <= conv_req & oscillator_run;             // see RULE14
      conv_refused <= conv_req & ~oscillator_run;
    end
  end

  // ----------------------------------------------------------------
  // Sample-rate unit
  // ----------------------------------------------------------------
  // Seconds into the current minute; restarts whenever the oscillator
  // stops, so a fresh start never fires a short first minute.
  logic [5:0] sec_count_reg;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sec_count_reg <= sarc_pkg::MIN_RESET;
    end else if (clk_en) begin
      if (!oscillator_run) begin
        sec_count_reg <= sarc_pkg::MIN_RESET;
      end else if (second_tick) begin
        if (sec_count_reg == sarc_pkg::MIN_LAST) begin
          sec_count_reg <= sarc_pkg::MIN_RESET;
        end else begin
          sec_count_reg <= sec_count_reg + 6'h01;
        end
      end
    end
  end

  // Stopped oscillator means no time base at all
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sample_unit_tick <= 1'b0;
    end else if (clk_en) begin
      sample_unit_tick <= oscillator_run & second_tick
        & (seconds_unit_select | (sec_count_reg == sarc_pkg::MIN_LAST));  // see RULE15
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Unmapped addresses read as zero rather than echoing a neighbour
  function automatic logic [7:0] read_mux(input logic [9:0] a);
    case (a)
      sarc_pkg::TEMP_LOW_ADDR:   read_mux = temp_low_threshold_reg;
      sarc_pkg::TEMP_HIGH_ADDR:  read_mux = temp_high_threshold_reg;
      sarc_pkg::HUMID_LOW_ADDR:  read_mux = humid_low_threshold_reg;
      sarc_pkg::HUMID_HIGH_ADDR: read_mux = humid_high_threshold_reg;
      sarc_pkg::TEMP_CTRL_ADDR:
        read_mux = sarc_pkg::ZERO_FILL | {6'h00, temp_alarm_enables_reg};    // see RULE11
      sarc_pkg::HUMID_CTRL_ADDR:
        read_mux = sarc_pkg::HUMID_FILL | {6'h00, humid_alarm_enables_reg};  // see RULE12
      sarc_pkg::CLOCK_CTRL_ADDR:
        read_mux = sarc_pkg::ZERO_FILL | {6'h00, clock_control_reg};         // see RULE11
      sarc_pkg::ALARM_FLAGS_ADDR:
        read_mux = sarc_pkg::FLAGS_FILL | {brownout_flag_reg, 3'h0,
                                           alarm_flags_reg};    // see RULE5 see RULE9
      default:                   read_mux = sarc_pkg::UNMAPPED_RD;
    endcase
  endfunction

  sarc_pkg::sarc_rd_state_t rd_state_reg;
  sarc_pkg::sarc_rd_state_t rd_state_next;

  always_comb begin
    case (rd_state_reg)
      sarc_pkg::SARC_RD_IDLE: begin
        rd_state_next = reg_rd ? sarc_pkg::SARC_RD_ANSWER : sarc_pkg::SARC_RD_IDLE;
      end
      sarc_pkg::SARC_RD_ANSWER: begin
        rd_state_next = sarc_pkg::SARC_RD_IDLE;
      end
      default: begin
        rd_state_next = sarc_pkg::SARC_RD_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_state_reg <= sarc_pkg::SARC_RD_IDLE;
    end else if (clk_en) begin
      rd_state_reg <= rd_state_next;
    end
  end

  // Data is captured with the request so the answer shows the
  // register as it stood when the read was asked for.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= sarc_pkg::BYTE_RESET;
    end else if (clk_en && reg_rd && rd_state_reg == sarc_pkg::SARC_RD_IDLE) begin
      reg_rdata <= read_mux(reg_addr);
    end
  end

  assign reg_rvalid = (rd_state_reg == sarc_pkg::SARC_RD_ANSWER);

endmodule

/* sim/sarc_ctrl_checker.sv */
`timescale 1ns/10ps
module sarc_ctrl_checker (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Register and mission strobes
  input wire logic reg_rd,
  input wire logic reg_rvalid,
  input wire logic mission_active,
  input wire logic mission_start,
  // Conversion guard
  input wire logic conv_req,
  input wire logic conv_start,
  input wire logic conv_refused,
  // Clock and alarm outputs
  input wire logic second_tick,
  input wire logic oscillator_run,
  input wire logic seconds_unit_select,
  input wire logic sample_unit_tick,
  input wire logic alarm_any
);
  // ------------------------------------------
  // Port relations
  // ------------------------------------------
  default clocking dc @(posedge mclk); endclocking
  default disable iff (!reset_n);

  a_read_answer: assert property (reg_rd && clk_en && !reg_rvalid |=> reg_rvalid)
    else $error("read not answered next cycle");
  a_rvalid_pulse: assert property (reg_rvalid && clk_en |=> !reg_rvalid)
    else $error("read answer longer than one cycle");
  a_conv_start: assert property (conv_req && clk_en && oscillator_run
    |=> conv_start && !conv_refused)
    else $error("conversion not started with oscillator running");
  a_conv_refuse: assert property (conv_req && clk_en && !oscillator_run
    |=> conv_refused && !conv_start)
    else $error("conversion not refused with oscillator stopped");
  a_tick_seconds: assert property (second_tick && clk_en && oscillator_run
    && seconds_unit_select |=> sample_unit_tick)
    else $error("seconds unit missed a tick");
  a_tick_stopped: assert property (clk_en && !oscillator_run |=> !sample_unit_tick)
    else $error("sample tick with oscillator stopped");
  a_tick_cause: assert property (sample_unit_tick && $past(clk_en) |-> $past(second_tick))
    else $error("sample tick without a second tick");
  a_flag_hold: assert property (alarm_any && !mission_start |=> alarm_any)
    else $error("alarm cleared during mission");
  a_idle_no_alarm: assert property (!alarm_any && !mission_active |=> !alarm_any)
    else $error("alarm raised outside a mission");
endmodule

bind sarc_ctrl sarc_ctrl_checker u_chk (.mclk, .reset_n, .clk_en, .reg_rd, .reg_rvalid,
  .mission_active, .mission_start, .conv_req, .conv_start, .conv_refused, .second_tick,
  .oscillator_run, .seconds_unit_select, .sample_unit_tick, .alarm_any);

/* sim/sarc_host_model.sv */
`timescale 1ns/10ps
module sarc_host_model (
  // Clock
  input  wire logic       mclk,
  // Register port toward the device
  output logic      [9:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  initial begin
    {reg_addr, reg_wr, reg_wdata, reg_rd} = '0;
  end

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
    // Released lines must not look like a held value
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask

  task automatic rd(input logic [9:0] a, output logic [7:0] d, output logic to);
    to = 1'b1;
    d  = 8'h00;
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    for (int i = 0; i < 4 && to; i++) begin
      @(posedge mclk);
      if (reg_rvalid === 1'b1) begin
        d  = reg_rdata;
        to = 1'b0;
      end
    end
    reg_addr <= ~a;
  endtask
endmodule

/* sim/tb_sensor_alarm_rtc_control.sv */
`timescale 1ns/10ps
module tb_sensor_alarm_rtc_control;
  // ------------------------------------------
  // Signals and reference state
  // ------------------------------------------
  logic        mclk, reset_n, clk_en, mission_active, mission_start, brownout_event;
  logic        temp_valid, humid_valid, conv_req, second_tick, reg_wr, reg_rd;
  logic        reg_rvalid, conv_start, conv_refused, oscillator_run;
  logic        seconds_unit_select, sample_unit_tick, alarm_any, bor;
  logic [9:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  logic [15:0] temp_result, humid_result;
  logic [7:0]  sh [10'h208:10'h214];
  logic [3:0]  flg;
  int          errors, cmp_count, ticks, seed;

  sarc_ctrl u_dut (.mclk, .reset_n, .clk_en, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
    .reg_rdata, .reg_rvalid, .mission_active, .mission_start, .brownout_event,
    .temp_result, .temp_valid, .humid_result, .humid_valid, .conv_req, .conv_start,
    .conv_refused, .second_tick, .oscillator_run, .seconds_unit_select,
    .sample_unit_tick, .alarm_any);
  sarc_host_model u_host (.mclk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
    .reg_rvalid);

  always #10 mclk = ~mclk;
  always @(posedge mclk) if (sample_unit_tick === 1'b1) ticks++;
  initial begin
    #1_000_000;
    errors++;
    finish_test;
  end

  function automatic logic [7:0] exp_rd(logic [9:0] a);
    case (a)
      10'h208, 10'h209, 10'h20a, 10'h20b: return sh[a];
      10'h210, 10'h212: return {6'h00, sh[a][1:0]};
      10'h211: return {6'h3f, sh[a][1:0]};
      10'h214: return {bor, 3'h7, flg};
      default: return 8'h00;
    endcase
  endfunction

  function automatic logic [3:0] hits(logic [7:0] t, logic [7:0] h, logic tv, logic hv);
    return {hv & sh[10'h211][1] & (h >= sh[10'h20b]), hv & sh[10'h211][0] & (h <= sh[10'h20a]),
            tv & sh[10'h210][1] & (t >= sh[10'h209]), tv & sh[10'h210][0] & (t <= sh[10'h208])};
  endfunction

  task automatic chk(string n, logic [7:0] seen, logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic finish_test;
    $display("Comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic put(input logic [9:0] a, input logic [7:0] d);
    logic ok;
    ok = !mission_active && clk_en && (a inside {[10'h208:10'h20b], [10'h210:10'h212]});
    u_host.wr(a, d);
    if (ok) sh[a] = d;
  endtask

  task automatic rc(input logic [9:0] a);
    logic [7:0] d;
    logic       to;
    u_host.rd(a, d, to);
    if (to) begin
      errors++;
      finish_test;
    end
    chk($sformatf("reg %h", a), d, exp_rd(a));
  endtask

  task automatic smp(input logic [15:0] t, h, input logic tv, hv);
    @(posedge mclk);
    temp_result  <= t;
    humid_result <= h;
    temp_valid   <= tv;
    humid_valid  <= hv;
    if (mission_active) flg |= hits(t[15:8], h[15:8], tv, hv);
  endtask

  task automatic tk(input int n);
    repeat (n) begin
      @(posedge mclk) second_tick <= 1'b1;
      @(posedge mclk) second_tick <= 1'b0;
    end
    repeat (2) @(posedge mclk);
  endtask

  // ------------------------------------------
  // Main sequence
  // ------------------------------------------
  initial begin
    mclk = 1'b0;
    reset_n = 1'b0;
    clk_en = 1'b1;
    {mission_active, mission_start, brownout_event, temp_valid, humid_valid} = '0;
    {conv_req, second_tick, temp_result, humid_result, bor, flg} = '0;
    {errors, cmp_count, ticks} = '0;
    seed = 32'h79a8;
    foreach (sh[i]) sh[i] = 8'h00;
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (5) @(posedge mclk);
    for (int a = 'h208; a <= 'h215; a++) rc(10'(a));
    repeat (3) begin
      for (int a = 'h208; a <= 'h215; a++) put(10'(a), 8'($random(seed)));
      for (int a = 'h208; a <= 'h215; a++) rc(10'(a));
      chk("clk outs", {6'h00, seconds_unit_select, oscillator_run}, exp_rd(10'h212));
    end
    // A frozen clock enable must swallow the write
    clk_en <= 1'b0;
    u_host.wr(10'h208, ~sh[10'h208]);
    clk_en <= 1'b1;
    rc(10'h208);
    for (int m = 0; m < 3; m++) begin
      for (int a = 'h208; a <= 'h20b; a++) put(10'(a), 8'($random(seed)));
      put(10'h210, (m == 0) ? 8'h03 : 8'($random(seed)));
      put(10'h211, (m == 0) ? 8'h03 : 8'($random(seed)));
      @(posedge mclk) {mission_active, mission_start} <= 2'b11;
      @(posedge mclk) mission_start <= 1'b0;
      flg = 4'h0;
      for (int a = 'h208; a <= 'h212; a++) put(10'(a), 8'($random(seed)));
      for (int a = 'h208; a <= 'h212; a++) rc(10'(a));
      smp({sh[10'h208], 8'hff}, {sh[10'h20b], 8'h00}, 1'b1, 1'b1);
      smp({sh[10'h209], 8'h00}, {sh[10'h20a], 8'hff}, 1'b1, 1'b1);
      repeat (30) smp(16'($random(seed)), 16'($random(seed)), 1'($random(seed)), 1'($random(seed)));
      @(posedge mclk) {temp_valid, humid_valid} <= 2'b00;
      #1 chk("alarm_any", {7'h00, alarm_any}, {7'h00, |flg});
      rc(10'h214);
      @(posedge mclk) mission_active <= 1'b0;
      smp(16'h0000, 16'hffff, 1'b1, 1'b1);
      @(posedge mclk) {temp_valid, humid_valid} <= 2'b00;
      rc(10'h214);
    end
    @(posedge mclk) brownout_event <= 1'b1;
    @(posedge mclk) brownout_event <= 1'b0;
    bor = 1'b1;
    rc(10'h214);
    put(10'h212, 8'h03);
    ticks = 0;
    tk(7);
    chk("second ticks", 8'(ticks), 8'h07);
    put(10'h212, 8'h00);
    put(10'h212, 8'h01);
    ticks = 0;
    tk(120);
    chk("minute ticks", 8'(ticks), 8'h02);
    put(10'h212, 8'h00);
    ticks = 0;
    tk(4);
    chk("stopped ticks", 8'(ticks), 8'h00);
    // First pass asks for a conversion with the oscillator stopped on purpose
    for (int o = 0; o < 2; o++) begin
      put(10'h212, 8'(o));
      @(posedge mclk) conv_req <= 1'b1;
      @(posedge mclk) conv_req <= 1'b0;
      #1 chk("conv", {6'h00, conv_start, conv_refused}, (o == 1) ? 8'h02 : 8'h01);
    end
    put(10'h212, 8'h00);
    finish_test;
  end
endmodule
